/* pkg/pboc_pkg.sv */
// Constants for the pixel black-level and offset correction stage
package pboc_pkg;
  // Register offsets on the byte-wide register port
  localparam logic [7:0] PBOC_ADDR_BLCOEF = 8'h26;
  localparam logic [7:0] PBOC_ADDR_THA_HI = 8'h27;
  localparam logic [7:0] PBOC_ADDR_THA_LO = 8'h28;
  localparam logic [7:0] PBOC_ADDR_THB_HI = 8'h29;
  localparam logic [7:0] PBOC_ADDR_THB_LO = 8'h2A;
  localparam logic [7:0] PBOC_ADDR_PED = 8'h2B;
  // Reset value shared by every register
  localparam logic [7:0] PBOC_REG_RESET = 8'h00;
  // Writable bit masks; reserved bits hold and read zero
  localparam logic [7:0] PBOC_MASK_BLCOEF = 8'h3F;
  localparam logic [7:0] PBOC_MASK_LO = 8'hF0;
  localparam logic [7:0] PBOC_MASK_PED = 8'hFE;
  // Field positions
  localparam int PBOC_CLIP_MSB = 5;
  localparam int PBOC_CLIP_LSB = 3;
  localparam int PBOC_ALPHA_MSB = 2;
  localparam int PBOC_ALPHA_LSB = 0;
  localparam int PBOC_NIB_MSB = 7;
  localparam int PBOC_NIB_LSB = 4;
  localparam int PBOC_POL_BIT = 7;
  localparam int PBOC_MAG_MSB = 6;
  localparam int PBOC_MAG_LSB = 1;
  // Data path sizes
  localparam int PBOC_PIX_W = 12;
  localparam int PBOC_FRAC_W = 7;
  localparam int PBOC_ACC_W = PBOC_PIX_W + PBOC_FRAC_W;
  localparam int PBOC_FIFO_DEPTH = 32;
  localparam logic [11:0] PBOC_PIX_MAX = 12'hFFF;
endpackage

/* hw/pboc_top.sv */
// Pixel black-level averaging, offset correction, threshold registers and output FIFO
// Behaviour
// RULE1: Clip field code n drops the n top bits of each 12-bit black pixel.
// RULE2: Black pixels are exponentially averaged with the coefficient from bits 2:0.
// RULE3: A larger coefficient makes the average converge more slowly.
// RULE4: Threshold A bits 11:4 come from the whole byte at 0x27.
// RULE5: Threshold A bits 3:0 come from 0x28 bits 7:4; low nibble reserved.
// RULE6: Threshold B is byte 0x29 above the upper nibble of 0x2A.
// RULE7: Polarity bit 7 clear adds the offset, set subtracts it.
// RULE8: Offset magnitude is bits 6:1 of the pedestal adjust register.
// RULE9: Host always writes zero into bit 0 of the pedestal adjust register.
// RULE10: Clip and coefficient live in read/write register 0x26, zero after reset.
// RULE11: Offset-corrected pixels saturate to the 12-bit range, never wrap.
`timescale 1ns/10ps

module pboc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign inReady = (count_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign outValid = (count_r != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem_r[rdPtr_r];

  // Storage; no reset needed on the data words
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wrPtr_r] <= inData;
  end

  // Pointers and count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wrPtr_r <= wrPtr_r + AW'(1);
      if (pop)
        rdPtr_r <= rdPtr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module pboc_top
  import pboc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic pixValid,
  input wire logic pixBlack,
  input wire logic [11:0] pixData,
  output logic pixReady,
  output logic outValid,
  input wire logic outReady,
  output logic [11:0] outData,
  output logic [11:0] blackLevel,
  output logic [11:0] defectThresholdA,
  output logic [11:0] defectThresholdB
);
  logic [7:0] blackLevelCoefficients_r;
  logic [7:0] defectThresholdAHigh_r;
  logic [7:0] defectThresholdALow_r;
  logic [7:0] defectThresholdBHigh_r;
  logic [7:0] defectThresholdBLow_r;
  logic [7:0] pedestalAdjust_r;
  logic [PBOC_ACC_W-1:0] blackAcc_r;
  logic [PBOC_ACC_W-1:0] blackAcc_nxt;
  logic [2:0] clipCode;
  logic [2:0] alpha;
  logic offsetPolarity;
  logic [5:0] offsetMagnitude;
  logic [11:0] clipped;
  logic [PBOC_ACC_W-1:0] sampleScaled;
  logic signed [PBOC_ACC_W+1:0] accDiff;
  logic signed [PBOC_ACC_W+1:0] accStep;
  logic signed [14:0] corrSum;
  logic [11:0] corrected;
  logic fifoInValid;
  logic fifoInReady;
  logic blackTake;

  // Drops the top code bits of a pixel word
  function automatic logic [11:0] clip_msbs(input logic [11:0] d, input logic [2:0] code);
    clip_msbs = d & (PBOC_PIX_MAX >> code);
  endfunction

  // Clamps a signed sum into the unsigned 12-bit pixel range
  function automatic logic [11:0] sat_pix(input logic signed [14:0] v);
    if (v < 15'sd0)
      sat_pix = 12'h000;
    else if (v > $signed({3'b000, PBOC_PIX_MAX}))
      sat_pix = PBOC_PIX_MAX;
    else
      sat_pix = v[11:0];
  endfunction

  // Byte reads of the register file, one cycle after the strobe
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    case (a)
      PBOC_ADDR_BLCOEF: reg_read = blackLevelCoefficients_r;
      PBOC_ADDR_THA_HI: reg_read = defectThresholdAHigh_r;
      PBOC_ADDR_THA_LO: reg_read = defectThresholdALow_r;
      PBOC_ADDR_THB_HI: reg_read = defectThresholdBHigh_r;
      PBOC_ADDR_THB_LO: reg_read = defectThresholdBLow_r;
      PBOC_ADDR_PED: reg_read = pedestalAdjust_r;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Field extraction
  assign clipCode = blackLevelCoefficients_r[PBOC_CLIP_MSB:PBOC_CLIP_LSB]; // RULE1
  assign alpha = blackLevelCoefficients_r[PBOC_ALPHA_MSB:PBOC_ALPHA_LSB]; // RULE2
  assign offsetPolarity = pedestalAdjust_r[PBOC_POL_BIT]; // RULE7
  assign offsetMagnitude = pedestalAdjust_r[PBOC_MAG_MSB:PBOC_MAG_LSB]; // RULE8
  assign defectThresholdA = {defectThresholdAHigh_r, defectThresholdALow_r[PBOC_NIB_MSB:PBOC_NIB_LSB]}; // RULE4 RULE5
  assign defectThresholdB = {defectThresholdBHigh_r, defectThresholdBLow_r[PBOC_NIB_MSB:PBOC_NIB_LSB]}; // RULE6

  // Register writes; reserved bits are masked so they always read zero
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      blackLevelCoefficients_r <= PBOC_REG_RESET; // RULE10
      defectThresholdAHigh_r <= PBOC_REG_RESET;
      defectThresholdALow_r <= PBOC_REG_RESET;
      defectThresholdBHigh_r <= PBOC_REG_RESET;
      defectThresholdBLow_r <= PBOC_REG_RESET;
      pedestalAdjust_r <= PBOC_REG_RESET;
    end
    else if (regWrEn)
    begin
      case (regAddr)
        PBOC_ADDR_BLCOEF: blackLevelCoefficients_r <= regWrData & PBOC_MASK_BLCOEF; // RULE10
        PBOC_ADDR_THA_HI: defectThresholdAHigh_r <= regWrData; // RULE4
        PBOC_ADDR_THA_LO: defectThresholdALow_r <= regWrData & PBOC_MASK_LO; // RULE5
        PBOC_ADDR_THB_HI: defectThresholdBHigh_r <= regWrData; // RULE6
        PBOC_ADDR_THB_LO: defectThresholdBLow_r <= regWrData & PBOC_MASK_LO; // RULE6
        // Bit 0 is dropped so a host slip cannot disturb the magnitude
        PBOC_ADDR_PED: pedestalAdjust_r <= regWrData & PBOC_MASK_PED; // RULE9
        default: ;
      endcase
    end
  end

  // Read data and its valid flag
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRdEn;
      if (regRdEn)
        regRdData <= reg_read(regAddr);
    end
  end

  // Exponential average: acc moves by (sample - acc) / 2^alpha, so a bigger alpha is slower
  assign clipped = clip_msbs(pixData, clipCode); // RULE1
  assign sampleScaled = {clipped, PBOC_FRAC_W'(0)};
  assign accDiff = $signed({2'b00, sampleScaled}) - $signed({2'b00, blackAcc_r});
  assign accStep = accDiff >>> alpha; // RULE2 RULE3
  assign blackAcc_nxt = PBOC_ACC_W'($signed({2'b00, blackAcc_r}) + accStep);
  assign blackTake = pixValid && pixBlack;

  // Black-level accumulator; fractional bits keep small steps from stalling
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      blackAcc_r <= '0;
    else if (blackTake)
      blackAcc_r <= blackAcc_nxt; // RULE2
  end
  assign blackLevel = blackAcc_r[PBOC_ACC_W-1:PBOC_FRAC_W];

  // Active pixels: subtract black level, apply signed pedestal, clamp
  always_comb
  begin
    corrSum = $signed({3'b000, pixData}) - $signed({3'b000, blackLevel});
    if (offsetPolarity)
      corrSum = corrSum - $signed({9'h000, offsetMagnitude}); // RULE7 RULE8
    else
      corrSum = corrSum + $signed({9'h000, offsetMagnitude}); // RULE7 RULE8
  end
  assign corrected = sat_pix(corrSum); // RULE11

  // Black pixels are always consumed; active pixels stall when the FIFO is full
  assign fifoInValid = pixValid && !pixBlack;
  assign pixReady = pixBlack ? 1'b1 : fifoInReady;

  pboc_fifo #(
    .WIDTH(PBOC_PIX_W),
    .DEPTH(PBOC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(corrected),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outData)
  );

  // Checks
  logic fifoPush;
  assign fifoPush = fifoInValid && fifoInReady;

  sequence s_wr(logic [7:0] a);
    regWrEn && regAddr == a;
  endsequence

  property p_clip_direct;
    @(posedge clk_sys) disable iff (!rst_n)
      blackTake && alpha == 3'h0 |=> blackLevel == clip_msbs($past(pixData), $past(clipCode));
  endproperty
  a_clip_direct: assert property (p_clip_direct) else $error("black level not the clipped sample"); // RULE1

  property p_clip_range;
    @(posedge clk_sys) disable iff (!rst_n)
      blackTake && clipCode == 3'h7 && alpha == 3'h0 |=> blackLevel < 12'h020;
  endproperty
  a_clip_range: assert property (p_clip_range) else $error("clip code 7 kept too many bits"); // RULE1

  property p_avg_toward;
    @(posedge clk_sys) disable iff (!rst_n)
      blackTake && sampleScaled > blackAcc_r |=>
        blackAcc_r >= $past(blackAcc_r) && blackAcc_r <= $past(sampleScaled);
  endproperty
  a_avg_toward: assert property (p_avg_toward) else $error("average overshoots or moves away"); // RULE2

  property p_avg_slow;
    @(posedge clk_sys) disable iff (!rst_n)
      blackTake && alpha != 3'h0 && accDiff > 20'sh00100 |=> blackAcc_r < $past(sampleScaled);
  endproperty
  a_avg_slow: assert property (p_avg_slow) else $error("nonzero coefficient jumped to the sample"); // RULE3

  property p_tha_hi;
    @(posedge clk_sys) disable iff (!rst_n)
      s_wr(PBOC_ADDR_THA_HI) |=> defectThresholdA[11:4] == $past(regWrData);
  endproperty
  a_tha_hi: assert property (p_tha_hi) else $error("threshold A high byte not taken"); // RULE4

  property p_tha_lo;
    @(posedge clk_sys) disable iff (!rst_n)
      s_wr(PBOC_ADDR_THA_LO) |=> defectThresholdA[3:0] == $past(regWrData[7:4]);
  endproperty
  a_tha_lo: assert property (p_tha_lo) else $error("threshold A low nibble not taken"); // RULE5

  property p_thb;
    @(posedge clk_sys) disable iff (!rst_n)
      s_wr(PBOC_ADDR_THB_HI) ##2 s_wr(PBOC_ADDR_THB_LO) |=>
        defectThresholdB == {$past(regWrData, 3), $past(regWrData[7:4])};
  endproperty
  a_thb: assert property (p_thb) else $error("threshold B assembled wrongly"); // RULE6

  property p_offset_add;
    @(posedge clk_sys) disable iff (!rst_n)
      fifoPush && !offsetPolarity && blackLevel == 12'h000 && pixData < 12'hF00 |->
        corrected == pixData + 12'(offsetMagnitude);
  endproperty
  a_offset_add: assert property (p_offset_add) else $error("positive offset wrong"); // RULE8

  property p_offset_sub;
    @(posedge clk_sys) disable iff (!rst_n)
      fifoPush && offsetPolarity && pixData <= blackLevel |-> corrected == 12'h000;
  endproperty
  a_offset_sub: assert property (p_offset_sub) else $error("negative offset wrapped below zero"); // RULE7

  property p_sat_top;
    @(posedge clk_sys) disable iff (!rst_n)
      fifoPush && !offsetPolarity && blackLevel == 12'h000 && pixData == PBOC_PIX_MAX |->
        corrected == PBOC_PIX_MAX;
  endproperty
  a_sat_top: assert property (p_sat_top) else $error("full scale wrapped"); // RULE11

  property p_reset_coef;
    @(posedge clk_sys) !rst_n |=> blackLevelCoefficients_r == 8'h00 && pedestalAdjust_r == 8'h00;
  endproperty
  a_reset_coef: assert property (p_reset_coef) else $error("coefficient register not cleared"); // RULE10
endmodule

/* dv/pboc_host_model.sv */
// Host controller model driving the byte-wide register port
`timescale 1ns/10ps
module pboc_host_model
  import pboc_pkg::*;
(
  input wire logic clk_sys,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  // Quiet port from time zero so nothing is taken during reset
  initial
  begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // One byte write; strobe stands for exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge clk_sys);
    regAddr = a;
    regWrData = (a == PBOC_ADDR_PED) ? {d[7:1], 1'b0} : d;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
  end
  endtask

  // One byte read; answer is taken while its one-cycle valid stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    d = 8'hXX;
    if (regRdValid === 1'b1)
    begin
      d = regRdData;
    end
  end
  endtask
endmodule

/* dv/pboc_top_tb_top.sv */
// Self-checking bench for the pixel black-level and offset correction stage
`timescale 1ns/10ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pboc_top_tb_top
  import pboc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, regRdValid;
  logic pixValid, pixBlack, pixReady, outValid, outReady;
  logic [11:0] pixData, outData, blackLevel, defectThresholdA, defectThresholdB;
  int miscompares = 0;
  int nTests = 0;
  logic [7:0] d;
  logic [7:0] addrs [7] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h30};
  logic [7:0] masks [7] = '{8'h3F, 8'hFF, 8'hF0, 8'hFF, 8'hF0, 8'hFE, 8'h00};
  logic [7:0] peds [6] = '{8'h7E, 8'hFE, 8'hFE, 8'h7E, 8'h02, 8'hFE};
  logic [11:0] pixs [6] = '{12'h100, 12'h100, 12'h040, 12'hFF0, 12'h020, 12'h010};
  logic [11:0] exps [6] = '{12'h11F, 12'h0A1, 12'h000, 12'hFFF, 12'h001, 12'h000};

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  pboc_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .pixValid(pixValid), .pixBlack(pixBlack), .pixData(pixData), .pixReady(pixReady),
    .outValid(outValid), .outReady(outReady), .outData(outData), .blackLevel(blackLevel),
    .defectThresholdA(defectThresholdA), .defectThresholdB(defectThresholdB));

  pboc_host_model i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic final_report();
  begin
    if (miscompares == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // One pixel word, held until the stage takes it (bounded wait)
  task automatic pix(input logic blk, input logic [11:0] v);
    int n;
  begin
    @(negedge clk_sys);
    pixValid = 1'b1;
    pixBlack = blk;
    pixData = v;
    n = 0;
    #1;
    while (pixReady !== 1'b1 && n < 64)
    begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    // A word never taken is a failure, not a silent skip
    if (n >= 64)
      miscompares++;
    @(negedge clk_sys);
    pixValid = 1'b0;
  end
  endtask

  // Pop the FIFO head; the low cycle after it doubles as a sink stall
  task automatic pop();
  begin
    @(negedge clk_sys);
    outReady = 1'b1;
    @(negedge clk_sys);
    outReady = 1'b0;
  end
  endtask

  // Generous limit; the full sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end

  initial
  begin
    rst_n = 1'b0;
    pixValid = 1'b0;
    pixBlack = 1'b0;
    pixData = 12'h000;
    outReady = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    // Reset values, then writable bits of every register and an unmapped place
    foreach (addrs[i])
    begin
      i_host.rd(addrs[i], d);
      `CHK(d, PBOC_REG_RESET)
    end
    foreach (addrs[i])
    begin
      i_host.wr(addrs[i], 8'hFF);
      i_host.rd(addrs[i], d);
      `CHK(d, masks[i])
    end
    // Threshold assembly from high byte and upper nibble
    i_host.wr(8'h27, 8'hAB);
    i_host.wr(8'h28, 8'hCD);
    i_host.wr(8'h29, 8'h12);
    i_host.wr(8'h2A, 8'h3F);
    `CHK(defectThresholdA, 12'hABC)
    `CHK(defectThresholdB, 12'h123)
    // Every clip code with coefficient zero, so the average jumps
    i_host.wr(8'h2B, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      i_host.wr(8'h26, {2'b00, 3'(c), 3'b000});
      pix(1'b1, 12'hFFF);
      `CHK(blackLevel, 12'hFFF >> c)
    end
    // One step from zero: larger coefficient moves the average less
    for (int a = 1; a < 8; a++)
    begin
      i_host.wr(8'h26, 8'h00);
      pix(1'b1, 12'h000);
      i_host.wr(8'h26, {5'b00000, 3'(a)});
      pix(1'b1, 12'h800);
      `CHK(blackLevel, 12'h800 >> a)
    end
    // Offset polarity, magnitude and saturation with black level 0x020
    i_host.wr(8'h26, 8'h00);
    pix(1'b1, 12'h020);
    foreach (peds[i])
    begin
      i_host.wr(8'h2B, peds[i]);
      pix(1'b0, pixs[i]);
      `CHK(outValid, 1'b1)
      `CHK(outData, exps[i])
      pop();
    end
    // Full scale with black level zero and a positive offset must clamp
    pix(1'b1, 12'h000);
    i_host.wr(8'h2B, 8'h7E);
    pix(1'b0, PBOC_PIX_MAX);
    `CHK(outData, PBOC_PIX_MAX)
    pop();
    // Fill the FIFO until it refuses, then drain with sink stalls
    i_host.wr(8'h2B, 8'h00);
    for (int i = 0; i < PBOC_FIFO_DEPTH; i++)
      pix(1'b0, 12'(i));
    @(negedge clk_sys);
    pixValid = 1'b1;
    pixBlack = 1'b0;
    pixData = 12'h0AA;
    #1;
    `CHK(pixReady, 1'b0)
    @(negedge clk_sys);
    pixValid = 1'b0;
    for (int i = 0; i < PBOC_FIFO_DEPTH; i++)
    begin
      `CHK(outData, 12'(i))
      pop();
    end
    `CHK(outValid, 1'b0)
    `CHK(pixReady, 1'b1)
    // Reset in mid-run clears the registers and the black level again
    i_host.wr(8'h26, 8'h2D);
    pix(1'b1, 12'h7FF);
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK(blackLevel, 12'h000)
    i_host.rd(8'h26, d);
    `CHK(d, PBOC_REG_RESET)
    final_report();
  end
endmodule
